//--- src/nbl_pkg.sv
// Package: constants for the NAND block-lock host controller
// How it works
// - Unlock is 23h+lower then 24h+upper
// - Page LSB carries invert, other bits zero
// - Host keeps lower strictly below upper
// - Three address cycles, fixed bit placement
// - Host confirms WP high before lock-tight
// - 7Ah plus block address returns status byte
package nbl_pkg;
  // ****************************************************************
  // Register map of the controller
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_LOWER = 12'h004;
  localparam logic [11:0] ADDR_UPPER = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_RESULT = 12'h010;
  // Control fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 4;
  localparam int CTRL_INV_BIT = 8;
  localparam int CTRL_WP_BIT = 9;
  // Operations requested through the control register
  localparam logic [2:0] OP_UNLOCK = 3'h0;
  localparam logic [2:0] OP_LOCK_ALL = 3'h1;
  localparam logic [2:0] OP_TIGHT = 3'h2;
  localparam logic [2:0] OP_READ_STAT = 3'h3;
  // ****************************************************************
  // Device command codes and field positions
  // ****************************************************************
  localparam logic [7:0] CMD_UNLOCK_LO = 8'h23;
  localparam logic [7:0] CMD_UNLOCK_HI = 8'h24;
  localparam logic [7:0] CMD_LOCK_ALL = 8'h2A;
  localparam logic [7:0] CMD_TIGHT = 8'h2C;
  localparam logic [7:0] CMD_READ_STAT = 8'h7A;
  localparam int BLK_W = 18;
  localparam int BA_LOW_LSB = 6;
  localparam int BA_MID_LSB = 8;
  localparam int BA_TOP_LSB = 16;
  // ****************************************************************
  // Bus timing, in ns, and cycle counts at 200 MHz
  // ****************************************************************
  localparam int CLK_PS = 5000;
  localparam int T_WP_NS = 25;
  localparam int T_REA_NS = 25;
  localparam int WE_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int REA_CYC = (T_REA_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [3:0] WE_CNT = 4'(WE_CYC);
  localparam logic [3:0] REA_CNT = 4'(REA_CYC);
  typedef enum logic [6:0] {
    NBL_IDLE = 7'h01,
    NBL_CMD = 7'h02,
    NBL_ADDR = 7'h04,
    NBL_NEXT = 7'h08,
    NBL_READ = 7'h10,
    NBL_HOLD = 7'h20,
    NBL_DONE = 7'h40
  } nbl_state_t;
endpackage

//--- src/nbl_strobe.sv
// Strobe timer: one write or read strobe of fixed length
`timescale 1ns/100ps
`default_nettype none
module nbl_strobe (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic start, // Pulse: begin a strobe
  input wire logic [3:0] len, // Strobe length in cycles
  output logic active, // Strobe low phase running
  output logic done // Pulse: strobe finished
);
  logic [3:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      active <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= len;
        active <= 1'b1;
      end else if (active) begin
        if (cnt <= 4'h1) begin
          active <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- src/nbl_host.sv
// Host controller issuing block-lock commands to a NAND device
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module nbl_host (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic nand_ce_n, // Chip enable, active low
  output logic nand_cle, // Command latch enable
  output logic nand_ale, // Address latch enable
  output logic nand_we_n, // Write enable, active low
  output logic nand_re_n, // Read enable, active low
  output logic nand_wp_n, // Write protect, active low
  output logic [7:0] nand_io_o, // I/O drive value
  output logic nand_io_oe, // I/O drive enable
  input wire logic [7:0] nand_io_i, // I/O sampled value
  input wire logic nand_rb_n // Ready/busy, low when busy
);
  nbl_pkg::nbl_state_t state;
  logic [2:0] op;
  logic [nbl_pkg::BLK_W-1:0] lower_blk;
  logic [nbl_pkg::BLK_W-1:0] upper_blk;
  logic invert;
  logic busy;
  logic [7:0] result;
  logic [1:0] acyc;
  logic second;
  logic st_start;
  logic [3:0] st_len;
  logic st_active;
  logic st_done;
  logic apb_wr;
  logic go;
  logic [2:0] req_op;
  logic cmd_ok;

  // Address byte n of a block in the three-cycle lock format
  function automatic logic [7:0] addr_byte(
    input logic [nbl_pkg::BLK_W-1:0] blk,
    input logic inv,
    input logic [1:0] n
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (n)
      2'h0: b = {blk[nbl_pkg::BA_LOW_LSB+1 -: 2], 5'h00, inv};
      2'h1: b = blk[nbl_pkg::BA_MID_LSB +: 8];
      default: b = {6'h00, blk[nbl_pkg::BA_TOP_LSB +: 2]};
    endcase
    return b;
  endfunction

  // Opcode for the current step of the sequence
  function automatic logic [7:0] op_cmd(input logic [2:0] o,
                                         input logic sec);
    logic [7:0] c;
    c = nbl_pkg::CMD_READ_STAT;
    if (o == nbl_pkg::OP_UNLOCK) begin
      c = sec ? nbl_pkg::CMD_UNLOCK_HI : nbl_pkg::CMD_UNLOCK_LO;
    end else if (o == nbl_pkg::OP_LOCK_ALL) begin
      c = nbl_pkg::CMD_LOCK_ALL;
    end else if (o == nbl_pkg::OP_TIGHT) begin
      c = nbl_pkg::CMD_TIGHT;
    end
    return c;
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign apb_wr = psel && penable && pwrite && pready;
  assign go = apb_wr && (paddr == nbl_pkg::ADDR_CTRL) &&
              pwdata[nbl_pkg::CTRL_GO_BIT] && !busy;

  // Never send a reversed range, nor lock-tight with WP asserted
  assign req_op = pwdata[nbl_pkg::CTRL_OP_LSB +: 3];
  assign cmd_ok =
    (req_op != nbl_pkg::OP_UNLOCK ||
     lower_blk[nbl_pkg::BLK_W-1:nbl_pkg::BA_LOW_LSB] <
     upper_blk[nbl_pkg::BLK_W-1:nbl_pkg::BA_LOW_LSB]) &&
    (req_op != nbl_pkg::OP_TIGHT ||
     (nand_wp_n && !pwdata[nbl_pkg::CTRL_WP_BIT]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        unique case (paddr)
          nbl_pkg::ADDR_CTRL:
            prdata <= {22'h000000, nand_wp_n ? 1'b0 : 1'b1, invert,
                       1'b0, op, 3'h0, busy};
          nbl_pkg::ADDR_LOWER: prdata <= {14'h0000, lower_blk};
          nbl_pkg::ADDR_UPPER: prdata <= {14'h0000, upper_blk};
          nbl_pkg::ADDR_STATUS:
            prdata <= {30'h00000000, nand_rb_n, busy};
          nbl_pkg::ADDR_RESULT: prdata <= {24'h000000, result};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // Software settings
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= nbl_pkg::OP_UNLOCK;
      invert <= 1'b0;
      lower_blk <= '0;
      upper_blk <= '0;
      nand_wp_n <= 1'b1;
    end else if (apb_wr) begin
      if (paddr == nbl_pkg::ADDR_CTRL) begin
        nand_wp_n <= !pwdata[nbl_pkg::CTRL_WP_BIT];
        if (!busy) begin
          op <= pwdata[nbl_pkg::CTRL_OP_LSB +: 3];
          invert <= pwdata[nbl_pkg::CTRL_INV_BIT];
        end
      end else if (paddr == nbl_pkg::ADDR_LOWER && !busy) begin
        lower_blk <= pwdata[nbl_pkg::BLK_W-1:0];
      end else if (paddr == nbl_pkg::ADDR_UPPER && !busy) begin
        upper_blk <= pwdata[nbl_pkg::BLK_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Device sequencer
  // ****************************************************************
  assign st_len = (state == nbl_pkg::NBL_READ) ? nbl_pkg::REA_CNT
                                       : nbl_pkg::WE_CNT;

  nbl_strobe u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .start(st_start),
    .len(st_len),
    .active(st_active),
    .done(st_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= nbl_pkg::NBL_IDLE;
      busy <= 1'b0;
      st_start <= 1'b0;
      acyc <= 2'h0;
      second <= 1'b0;
      result <= 8'h00;
      nand_ce_n <= 1'b1;
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      nand_re_n <= 1'b1;
      nand_io_o <= 8'h00;
      nand_io_oe <= 1'b0;
    end else begin
      st_start <= 1'b0;
      unique case (state)
        nbl_pkg::NBL_IDLE: begin
          if (go && cmd_ok) begin
            busy <= 1'b1;
            second <= 1'b0;
            nand_ce_n <= 1'b0;
            state <= nbl_pkg::NBL_CMD;
          end
        end
        nbl_pkg::NBL_CMD: begin
          // Setup for one command latch cycle
          nand_cle <= 1'b1;
          nand_io_oe <= 1'b1;
          nand_io_o <= op_cmd(op, second);
          nand_we_n <= 1'b0;
          st_start <= 1'b1;
          acyc <= 2'h0;
          state <= nbl_pkg::NBL_HOLD;
        end
        nbl_pkg::NBL_ADDR: begin
          nand_ale <= 1'b1;
          nand_io_oe <= 1'b1;
          // Lower boundary carries no invert; upper carries it
          nand_io_o <= addr_byte(second ? upper_blk : lower_blk,
                                 second && op == nbl_pkg::OP_UNLOCK
                                   && invert, acyc);
          nand_we_n <= 1'b0;
          st_start <= 1'b1;
          state <= nbl_pkg::NBL_HOLD;
        end
        nbl_pkg::NBL_HOLD: begin
          if (st_done) begin
            nand_we_n <= 1'b1;
            state <= nbl_pkg::NBL_NEXT;
          end
        end
        nbl_pkg::NBL_NEXT: begin
          nand_cle <= 1'b0;
          nand_ale <= 1'b0;
          if (op == nbl_pkg::OP_LOCK_ALL || op == nbl_pkg::OP_TIGHT) begin
            state <= nbl_pkg::NBL_DONE;
          end else if (!nand_ale) begin
            acyc <= 2'h0;
            state <= nbl_pkg::NBL_ADDR;
          end else if (acyc != 2'h2) begin
            acyc <= acyc + 2'h1;
            state <= nbl_pkg::NBL_ADDR;
          end else if (op == nbl_pkg::OP_UNLOCK && !second) begin
            second <= 1'b1;
            state <= nbl_pkg::NBL_CMD;
          end else if (op == nbl_pkg::OP_READ_STAT) begin
            nand_io_oe <= 1'b0;
            nand_re_n <= 1'b0;
            st_start <= 1'b1;
            state <= nbl_pkg::NBL_READ;
          end else begin
            state <= nbl_pkg::NBL_DONE;
          end
        end
        nbl_pkg::NBL_READ: begin
          // Data valid at end of read access time
          if (st_done) begin
            result <= nand_io_i;
            nand_re_n <= 1'b1;
            state <= nbl_pkg::NBL_DONE;
          end
        end
        nbl_pkg::NBL_DONE: begin
          nand_io_oe <= 1'b0;
          nand_ce_n <= 1'b1;
          busy <= 1'b0;
          state <= nbl_pkg::NBL_IDLE;
        end
        default: state <= nbl_pkg::NBL_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- tb/nbl_host_monitor.sv
// Checker on the NAND pins of the block-lock host
`timescale 1ns/100ps
`default_nettype none
module nbl_host_monitor (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic nand_ce_n, // Chip enable
  input wire logic nand_cle, // Command latch
  input wire logic nand_ale, // Address latch
  input wire logic nand_we_n, // Write strobe
  input wire logic nand_re_n, // Read strobe
  input wire logic [7:0] nand_io_o, // I/O value
  input wire logic nand_io_oe // I/O enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ce_strobe;
    !nand_we_n || !nand_re_n |-> !nand_ce_n;
  endproperty
  a_ce_strobe: assert property (p_ce_strobe)
    else $error("strobe without chip enable");
  property p_one_latch;
    !(nand_cle && nand_ale);
  endproperty
  a_one_latch: assert property (p_one_latch)
    else $error("command and address latch together");
  // Strobe timer adds one cycle at each end of the counted span
  property p_we_len;
    $fell(nand_we_n) |-> !nand_we_n [*7] ##1 nand_we_n;
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("write strobe length wrong");
  property p_io_hold;
    !nand_we_n && $past(!nand_we_n) || $rose(nand_we_n) |->
      nand_io_oe && $stable(nand_io_o) && $stable(nand_cle);
  endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("bus moved during write strobe");
  property p_re_len;
    $fell(nand_re_n) |-> !nand_re_n [*7] ##1 nand_re_n;
  endproperty
  a_re_len: assert property (p_re_len)
    else $error("read strobe length wrong");
  property p_re_free;
    !nand_re_n |-> !nand_io_oe && !nand_cle && !nand_ale;
  endproperty
  a_re_free: assert property (p_re_free)
    else $error("host drives bus while reading");
  property p_cmd_code;
    nand_cle && !nand_we_n |->
      nand_io_o inside {8'h23, 8'h24, 8'h2A, 8'h2C, 8'h7A};
  endproperty
  a_cmd_code: assert property (p_cmd_code)
    else $error("unknown command byte");
  c_read: cover property ($fell(nand_re_n));
  c_tight: cover property (nand_cle && nand_io_o == 8'h2C);
  c_err: cover property (pready && pslverr);
endmodule
bind nbl_host nbl_host_monitor u_mon (
  .pclk(pclk),
  .presetn(presetn),
  .pready(pready),
  .pslverr(pslverr),
  .nand_ce_n(nand_ce_n),
  .nand_cle(nand_cle),
  .nand_ale(nand_ale),
  .nand_we_n(nand_we_n),
  .nand_re_n(nand_re_n),
  .nand_io_o(nand_io_o),
  .nand_io_oe(nand_io_oe)
);
`default_nettype wire

//--- tb/nbl_nand_model.sv
// Behavioural NAND device with the block-lock feature only
`timescale 1ns/100ps
`default_nettype none
module nbl_nand_model (
  input wire logic ce_n, // Chip enable
  input wire logic cle, // Command latch
  input wire logic ale, // Address latch
  input wire logic we_n, // Write strobe
  input wire logic re_n, // Read strobe
  input wire logic wp_n, // Write protect
  input wire logic strap, // Lock enable strap
  input wire logic [7:0] din, // Bus from host
  output logic [7:0] dout, // Bus to host
  output logic rb_n // Ready/busy
);
  logic en, tight = 0, unl = 0, iv, inv, free, in_rng;
  logic [7:0] cmd;
  logic [17:0] a = 18'h0, lo, hi, sb;
  int n;
  initial #1 en = strap;
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      cmd = din;
      n = 0;
      if (en && !tight && din == 8'h2A) unl = 0;
      if (en && din == 8'h2C) tight = 1;
    end else if (ale) begin
      case (n)
        0: begin a[7:6] = din[7:6]; iv = din[0]; end
        1: a[15:8] = din;
        default: a[17:16] = din[1:0];
      endcase
      if (n == 2 && cmd == 8'h7A) sb = a;
      if (n == 2 && en && !tight && cmd == 8'h23) lo = a;
      if (n == 2 && en && !tight && cmd == 8'h24) begin
        hi = a;
        inv = iv;
        unl = 1;
      end
      n++;
    end
  end
  always @(negedge wp_n) if (!tight) unl = 0;
  assign in_rng = sb >= lo && sb <= hi;
  assign free = !en || unl && (wp_n || tight) && (inv ^ in_rng);
  // Idle bus shows the inverse so a stale byte never passes
  assign dout = {5'h00, free, !tight, tight} ^ {8{re_n || ce_n}};
  // No program or erase is ever sent, so never busy
  assign rb_n = 1'b1;
endmodule
`default_nettype wire

//--- tb/nbl_host_tb.sv
// Testbench of the block-lock host against the device model
`timescale 1ns/100ps
`default_nettype none
module nbl_host_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n, e;
  logic wp = 0;
  logic [7:0] io_o, io_i;
  int fail_count = 0, n_checks = 0;
  nbl_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nand_ce_n(ce_n),
    .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n),
    .nand_wp_n(wp_n), .nand_io_o(io_o), .nand_io_oe(oe),
    .nand_io_i(io_i), .nand_rb_n(rb_n));
  nbl_nand_model dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .strap(1'b1), .din(io_o), .dout(io_i),
    .rb_n(rb_n));
  initial forever #2.5 pclk = ~pclk;
  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic op(input logic [2:0] o, input logic iv);
    int n;
    apb(1, nbl_pkg::ADDR_CTRL, {22'h0, wp, iv, 1'b0, o, 4'h1});
    n = 0;
    do begin apb(0, nbl_pkg::ADDR_STATUS, 0); n++; end
      while (q[0] !== 1'b0 && n < 100);
    chk("status", 32'h2, q);
  endtask
  task automatic st(input logic [17:0] b, input logic [2:0] x);
    apb(1, nbl_pkg::ADDR_LOWER, {14'h0, b});
    op(nbl_pkg::OP_READ_STAT, 0);
    apb(0, nbl_pkg::ADDR_RESULT, 0);
    chk("lock_status", {29'h0, x}, q & 32'h7);
  endtask
  task automatic unl(input logic [17:0] l, h, input logic iv);
    apb(1, nbl_pkg::ADDR_LOWER, {14'h0, l});
    apb(1, nbl_pkg::ADDR_UPPER, {14'h0, h});
    op(nbl_pkg::OP_UNLOCK, iv);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    st(18'h10080, 3'b010);
    unl(18'h00040, 18'h30100, 0);
    st(18'h10080, 3'b110);
    st(18'h30140, 3'b010);
    unl(18'h00100, 18'h00200, 1);
    st(18'h10080, 3'b110);
    st(18'h00180, 3'b010);
    wp = 1;
    apb(1, nbl_pkg::ADDR_CTRL, 32'h200);
    @(posedge pclk);
    chk("wp_pin", 0, {31'h0, wp_n});
    wp = 0;
    apb(1, nbl_pkg::ADDR_CTRL, 32'h0);
    st(18'h10080, 3'b010);
    unl(18'h00100, 18'h00200, 0);
    op(nbl_pkg::OP_LOCK_ALL, 0);
    st(18'h00180, 3'b010);
    unl(18'h00200, 18'h00100, 1);
    st(18'h00180, 3'b010);
    wp = 1;
    op(nbl_pkg::OP_TIGHT, 0);
    wp = 0;
    st(18'h00180, 3'b010);
    unl(18'h00100, 18'h00200, 0);
    op(nbl_pkg::OP_TIGHT, 0);
    st(18'h00180, 3'b101);
    op(nbl_pkg::OP_LOCK_ALL, 0);
    unl(18'h00000, 18'h00040, 0);
    st(18'h00180, 3'b101);
    st(18'h00040, 3'b001);
    wp = 1;
    st(18'h00180, 3'b101);
    wp = 0;
    apb(0, 12'h020, 0);
    chk("slverr", 1, {31'h0, e});
    give_verdict;
  end
  // Whole sequence needs about 1240 cycles
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
